// file: hw/bisw_cfg.svh
// Constants for the binary-input and curve-select switch block.
// Assumes inclusion by the package, design and testbench files.
`ifndef BISW_CFG_SVH
`define BISW_CFG_SVH
// ********************************
// Register offsets
// ********************************
`define BISW_ADDR_W            4
`define BISW_OFF_CURVE_SEL     4'h0
`define BISW_OFF_ACTION_SEL    4'h1
`define BISW_OFF_PD_BLOCK      4'h2
`define BISW_OFF_STATUS        4'h3
`define BISW_OFF_CURVE_ACT     4'h4
// ********************************
// Reset values
// ********************************
`define BISW_RST_CURVE_SEL     8'h00
`define BISW_RST_ACTION_SEL    8'h00
`define BISW_RST_PD_BLOCK      1'h0
// ********************************
// Field positions in the action select switchgroup, and switch counts
// ********************************
`define BISW_ACT_CLR_IND       0
`define BISW_ACT_CLR_UNLATCH   1
`define BISW_ACT_CLR_ALL       2
`define BISW_ACT_GRP_SWITCH    3
`define BISW_ACT_BLK_LSB       4
`define BISW_NUM_CURVES        6
`define BISW_NUM_BLK           4
`endif

// file: hw/bisw_pkg.sv
// Types for the binary-input and curve-select switch block.
// Assumes the constants header is on the include path.
`include "bisw_cfg.svh"
package bisw_pkg;
   typedef enum logic [2:0] {
      BISW_CURVE_DT  = 3'h0,
      BISW_CURVE_EI  = 3'h1,
      BISW_CURVE_VI  = 3'h2,
      BISW_CURVE_NI  = 3'h3,
      BISW_CURVE_LTI = 3'h4,
      BISW_CURVE_RI  = 3'h5,
      BISW_CURVE_RD  = 3'h6
   } bisw_curve_t;
endpackage : bisw_pkg

// file: hw/bisw_sync.sv
// Two-stage synchroniser with a rising-edge pulse on the settled level.
// Assumes a single system clock; input may be fully asynchronous.
`timescale 1ns/1ns
module bisw_sync (
   input  wire logic sys_clk_i,
   input  wire logic nrst_i,
   input  wire logic async_i,
   output logic      level_o,
   output logic      rise_o
);
   logic meta_ff;
   logic sync_ff;
   logic prev_ff;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   // Edge taken only from the settled stage, never the first one
   assign level_o = sync_ff;
   assign rise_o  = sync_ff & ~prev_ff;
endmodule : bisw_sync

// file: hw/bisw_curve_pick.sv
// Priority pick of one characteristic from the one-hot curve switches.
// Assumes the curve switch register is stable in the system clock domain.
`timescale 1ns/1ns
`include "bisw_cfg.svh"
module bisw_curve_pick (
   input  wire logic [`BISW_NUM_CURVES-1:0] sel_i,
   output bisw_pkg::bisw_curve_t            curve_o
);
   import bisw_pkg::*;

   logic [`BISW_NUM_CURVES-1:0] lowest;

   // Lowest weighting factor wins when several switches are set
   assign lowest = sel_i & (~sel_i + `BISW_NUM_CURVES'(1)); // [R2]

   always_comb begin
      case (lowest) // [R1]
         6'h01:   curve_o = BISW_CURVE_EI;
         6'h02:   curve_o = BISW_CURVE_VI;
         6'h04:   curve_o = BISW_CURVE_NI;
         6'h08:   curve_o = BISW_CURVE_LTI;
         6'h10:   curve_o = BISW_CURVE_RI;
         6'h20:   curve_o = BISW_CURVE_RD;
         default: curve_o = BISW_CURVE_DT;
      endcase
   end
endmodule : bisw_curve_pick

// file: hw/bisw_top.sv
// Switchgroup logic: earth-fault curve select and binary input actions.
// Assumes one 25 MHz clock, a simple strobe register port, and a raw
// binary input straight from field wiring.
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "bisw_cfg.svh"

// Functional notes
// [R1] Six one-hot bits pick curve; none is definite-time
// [R2] Several bits set: lowest-numbered bit wins
// [R3] Switch one: input clears indications
// [R4] Switch two: clear indications and unlatch contacts
// [R5] Switch three: clear indications, memories, unlatch contacts
// [R6] Group switch on: input high selects group two
// [R7] Group switch off: input never changes group
// [R8] Software keeps group switch equal across groups
// [R9] Switches five-eight block four stage trips
// [R10] Second switchgroup bit blocks phase-discontinuity stage
// [R11] Input synchronised; clears on edge, blocks on level
module bisw_top (
   input  wire logic                      sys_clk_i,
   input  wire logic                      nrst_i,
   input  wire logic [`BISW_ADDR_W-1:0]   addr_i,
   input  wire logic [7:0]                wdata_i,
   input  wire logic                      wr_i,
   input  wire logic                      rd_i,
   output logic      [7:0]                rdata_o,
   input  wire logic                      external_binary_input_i,
   input  wire logic                      group_sel_sw_i,
   output bisw_pkg::bisw_curve_t          earth_fault_low_curve_o,
   output logic                           clear_indications_o,
   output logic                           unlatch_contacts_o,
   output logic                           clear_memorised_o,
   output logic                           setting_group2_o,
   output logic                           block_overcurrent_low_o,
   output logic                           block_overcurrent_high_o,
   output logic                           block_earth_fault_low_stage_o,
   output logic                           block_earth_fault_high_stage_o,
   output logic                           block_phase_discont_o
);
   import bisw_pkg::*;

   // ********************************
   // Registers
   // ********************************
   logic [7:0]  earth_fault_low_curve_select_ff;
   logic [7:0]  binary_input_action_select_ff;
   logic        binary_input_phase_discont_block_ff;
   logic [7:0]  rdata_ff;
   logic        clr_ind_ff;
   logic        unlatch_ff;
   logic        clr_mem_ff;
   logic        group2_ff;
   logic [`BISW_NUM_BLK-1:0] blk_ff;
   logic        blk_pd_ff;
   bisw_curve_t curve_ff;

   logic        bi_level;
   logic        bi_rise;
   bisw_curve_t nxt_curve;
   logic [7:0]  nxt_rdata;
   logic        nxt_clr_ind;
   logic        nxt_unlatch;
   logic        nxt_clr_mem;
   logic        nxt_group2;
   logic [`BISW_NUM_BLK-1:0] nxt_blk;
   logic        nxt_blk_pd;

   wire hit_curve  = (addr_i == `BISW_OFF_CURVE_SEL);
   wire hit_action = (addr_i == `BISW_OFF_ACTION_SEL);
   wire hit_pd     = (addr_i == `BISW_OFF_PD_BLOCK);
   wire hit_status = (addr_i == `BISW_OFF_STATUS);
   wire hit_cact   = (addr_i == `BISW_OFF_CURVE_ACT);

   wire sw_clr_ind = binary_input_action_select_ff[`BISW_ACT_CLR_IND];
   wire sw_clr_unl = binary_input_action_select_ff[`BISW_ACT_CLR_UNLATCH];
   wire sw_clr_all = binary_input_action_select_ff[`BISW_ACT_CLR_ALL];
   wire sw_grp     = binary_input_action_select_ff[`BISW_ACT_GRP_SWITCH];

   // ********************************
   // Binary input conditioning
   // ********************************
   bisw_sync u_sync (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .async_i   (external_binary_input_i),
      .level_o   (bi_level), // [R11]
      .rise_o    (bi_rise)
   );

   // ********************************
   // Curve selection
   // ********************************
   bisw_curve_pick u_pick (
      .sel_i   (earth_fault_low_curve_select_ff[`BISW_NUM_CURVES-1:0]),
      .curve_o (nxt_curve)
   );

   // ********************************
   // Actions and blocking
   // ********************************
   // Clears are single-cycle pulses so a held input does not keep wiping
   assign nxt_clr_ind = bi_rise & (sw_clr_ind | sw_clr_unl | sw_clr_all); // [R3] [R4] [R5]
   assign nxt_unlatch = bi_rise & (sw_clr_unl | sw_clr_all); // [R4] [R5]
   assign nxt_clr_mem = bi_rise & sw_clr_all; // [R5]
   // Group switch off leaves the externally chosen group in charge
   assign nxt_group2  = sw_grp ? bi_level : group_sel_sw_i; // [R6] [R7]
   assign nxt_blk_pd  = bi_level & binary_input_phase_discont_block_ff; // [R10]

   genvar g;
   generate
      for (g = 0; g < `BISW_NUM_BLK; g = g + 1) begin : g_blk
         assign nxt_blk[g] = bi_level &
                             binary_input_action_select_ff[`BISW_ACT_BLK_LSB + g]; // [R9]
      end
   endgenerate

   // ********************************
   // Read mux
   // ********************************
   assign nxt_rdata = hit_curve  ? earth_fault_low_curve_select_ff :
                      hit_action ? binary_input_action_select_ff :
                      hit_pd     ? {7'h00, binary_input_phase_discont_block_ff} :
                      hit_status ? {blk_pd_ff, blk_ff, group2_ff, bi_level, 1'b0} :
                      hit_cact   ? {5'h00, curve_ff} :
                                   8'h00;

   // ********************************
   // Register file
   // ********************************
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         earth_fault_low_curve_select_ff     <= `BISW_RST_CURVE_SEL;
         binary_input_action_select_ff       <= `BISW_RST_ACTION_SEL;
         binary_input_phase_discont_block_ff <= `BISW_RST_PD_BLOCK;
      end else if (wr_i) begin
         if (hit_curve) begin
            earth_fault_low_curve_select_ff <= wdata_i;
         end
         if (hit_action) begin
            binary_input_action_select_ff <= wdata_i;
         end
         if (hit_pd) begin
            binary_input_phase_discont_block_ff <= wdata_i[0];
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= rd_i ? nxt_rdata : 8'h00;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         curve_ff   <= BISW_CURVE_DT;
         clr_ind_ff <= 1'b0;
         unlatch_ff <= 1'b0;
         clr_mem_ff <= 1'b0;
         group2_ff  <= 1'b0;
         blk_ff     <= '0;
         blk_pd_ff  <= 1'b0;
      end else begin
         curve_ff   <= nxt_curve;
         clr_ind_ff <= nxt_clr_ind;
         unlatch_ff <= nxt_unlatch;
         clr_mem_ff <= nxt_clr_mem;
         group2_ff  <= nxt_group2;
         blk_ff     <= nxt_blk;
         blk_pd_ff  <= nxt_blk_pd;
      end
   end

   assign rdata_o                        = rdata_ff;
   assign earth_fault_low_curve_o        = curve_ff;
   assign clear_indications_o            = clr_ind_ff;
   assign unlatch_contacts_o             = unlatch_ff;
   assign clear_memorised_o              = clr_mem_ff;
   assign setting_group2_o               = group2_ff;
   assign block_overcurrent_low_o        = blk_ff[0];
   assign block_overcurrent_high_o       = blk_ff[1];
   assign block_earth_fault_low_stage_o  = blk_ff[2];
   assign block_earth_fault_high_stage_o = blk_ff[3];
   assign block_phase_discont_o          = blk_pd_ff;
endmodule : bisw_top

// file: tb/bisw_props.sv
// Checker: port-level timing and value relations of the switchgroup block.
// Assumes the constants header on the include path; attached by bind below.
`timescale 1ns/1ns
`include "bisw_cfg.svh"
module bisw_props (
   input wire logic                    sys_clk_i,
   input wire logic                    nrst_i,
   input wire logic [`BISW_ADDR_W-1:0] addr_i,
   input wire logic [7:0]              wdata_i,
   input wire logic                    wr_i,
   input wire logic                    rd_i,
   input wire logic [7:0]              rdata_o,
   input wire logic                    external_binary_input_i,
   input wire logic                    group_sel_sw_i,
   input wire bisw_pkg::bisw_curve_t   earth_fault_low_curve_o,
   input wire logic                    clear_indications_o,
   input wire logic                    unlatch_contacts_o,
   input wire logic                    clear_memorised_o,
   input wire logic                    setting_group2_o,
   input wire logic                    block_overcurrent_low_o,
   input wire logic                    block_overcurrent_high_o,
   input wire logic                    block_earth_fault_low_stage_o,
   input wire logic                    block_earth_fault_high_stage_o,
   input wire logic                    block_phase_discont_o
);
   import bisw_pkg::*;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   // Lowest switch wins; scanned downward so the last hit is the lowest
   function automatic logic [2:0] pick_f(input logic [7:0] d);
      pick_f = 3'h0;
      for (int i = 5; i >= 0; i--) if (d[i]) pick_f = 3'(i + 1);
   endfunction : pick_f
   // ****************************************
   // Properties
   // ****************************************
   a_curve_after_write: assert property (wr_i && addr_i == `BISW_OFF_CURVE_SEL |->
      ##2 earth_fault_low_curve_o == pick_f($past(wdata_i, 2))) else $error("curve code wrong");
   a_clear_on_rise: assert property (clear_indications_o |->
      $past(external_binary_input_i, 3) && !$past(external_binary_input_i, 4))
      else $error("clear without input edge");
   a_unlatch_with_clr: assert property (unlatch_contacts_o |-> clear_indications_o)
      else $error("unlatch without clear");
   a_mem_with_all: assert property (clear_memorised_o |->
      unlatch_contacts_o && clear_indications_o) else $error("memory clear alone");
   a_group_source: assert property ($rose(setting_group2_o) |->
      $past(external_binary_input_i, 3) || $past(group_sel_sw_i) || $past(group_sel_sw_i, 2))
      else $error("group two without cause");
   a_stage_block_level: assert property (block_overcurrent_low_o || block_overcurrent_high_o ||
      block_earth_fault_low_stage_o || block_earth_fault_high_stage_o |->
      $past(external_binary_input_i, 3)) else $error("stage blocked without input");
   a_pd_block_level: assert property (block_phase_discont_o |->
      $past(external_binary_input_i, 3)) else $error("discontinuity blocked without input");
   a_pulse_single: assert property (clear_indications_o |=> !clear_indications_o)
      else $error("clear pulse too long");
endmodule : bisw_props
bind bisw_top bisw_props u_props (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .external_binary_input_i(external_binary_input_i), .group_sel_sw_i(group_sel_sw_i),
   .earth_fault_low_curve_o(earth_fault_low_curve_o), .clear_indications_o(clear_indications_o),
   .unlatch_contacts_o(unlatch_contacts_o), .clear_memorised_o(clear_memorised_o),
   .setting_group2_o(setting_group2_o), .block_overcurrent_low_o(block_overcurrent_low_o),
   .block_overcurrent_high_o(block_overcurrent_high_o),
   .block_earth_fault_low_stage_o(block_earth_fault_low_stage_o),
   .block_earth_fault_high_stage_o(block_earth_fault_high_stage_o),
   .block_phase_discont_o(block_phase_discont_o));

// file: tb/bisw_bi_src.sv
// Field wiring model driving the relay's binary input.
// Assumes the bench commands the contact level; edges land off the clock grid.
`timescale 1ns/1ns
module bisw_bi_src (
   input  wire logic cmd_i,
   output logic      bi_o
);
   // Delay keeps edges asynchronous to the relay clock; bounce is not modelled
   initial bi_o = 1'b0;
   always @(cmd_i) bi_o <= #13 cmd_i;
endmodule : bisw_bi_src

// file: tb/tb_bisw_top.sv
// Testbench for the switchgroup block: register port tests and input actions.
// Assumes the checker is bound in and the wiring model drives the input.
`timescale 1ns/1ns
`include "bisw_cfg.svh"
module tb_bisw_top;
   import bisw_pkg::*;
   logic        sys_clk_i, nrst_i, wr_i, rd_i, cmd, gsel, bi;
   logic [3:0]  addr_i;
   logic [7:0]  wdata_i, rdata_o;
   bisw_curve_t curve;
   logic        clr, unl, mem, grp2, b0, b1, b2, b3, bpd;
   int          n_errors, num_checks, n_clr, n_unl, n_mem;
   bisw_bi_src u_src (.cmd_i(cmd), .bi_o(bi));
   bisw_top dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .external_binary_input_i(bi),
      .group_sel_sw_i(gsel), .earth_fault_low_curve_o(curve), .clear_indications_o(clr),
      .unlatch_contacts_o(unl), .clear_memorised_o(mem), .setting_group2_o(grp2),
      .block_overcurrent_low_o(b0), .block_overcurrent_high_o(b1),
      .block_earth_fault_low_stage_o(b2), .block_earth_fault_high_stage_o(b3),
      .block_phase_discont_o(bpd));
   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      n_clr += clr;
      n_unl += unl;
      n_mem += mem;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic hold(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : hold
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 chk("rdata", rdata_o, e);
   endtask : rd
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      #80000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      {nrst_i, wr_i, rd_i, cmd, gsel, addr_i, wdata_i} = '0;
      hold(12);
      nrst_i <= 1'b1;
      for (int a = 0; a < 3; a++) rd(4'(a), 8'h00);
      wr(4'h5, 8'hA5);
      rd(4'h5, 8'h00);
      chk("curve", {5'h00, curve}, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         wr(`BISW_OFF_CURVE_SEL, 8'hFF << i);
         rd(`BISW_OFF_CURVE_SEL, 8'hFF << i);
         rd(`BISW_OFF_CURVE_ACT, 8'(i + 1));
         chk("curve", {5'h00, curve}, 8'(i + 1));
      end
      wr(`BISW_OFF_CURVE_SEL, 8'hC0);
      rd(`BISW_OFF_CURVE_ACT, 8'h00);
      $display("test curve done");
      for (int j = 0; j < 4; j++) begin
         wr(`BISW_OFF_ACTION_SEL, (j == 0) ? 8'h00 : 8'h01 << (j - 1));
         #1 {n_clr, n_unl, n_mem} = '0;
         cmd <= 1'b1;
         hold(8);
         cmd <= 1'b0;
         hold(8);
         chk("clears", 8'(n_clr), {7'h00, j > 0});
         chk("unlatches", 8'(n_unl), {7'h00, j > 1});
         chk("memory clears", 8'(n_mem), {7'h00, j > 2});
      end
      $display("test actions done");
      wr(`BISW_OFF_ACTION_SEL, 8'hF8);
      wr(`BISW_OFF_PD_BLOCK, 8'hFF);
      rd(`BISW_OFF_PD_BLOCK, 8'h01);
      cmd <= 1'b1;
      hold(6);
      chk("blocks", {2'h0, grp2, bpd, b0, b1, b2, b3}, 8'h3F);
      rd(`BISW_OFF_STATUS, 8'hFE);
      cmd <= 1'b0;
      hold(6);
      chk("blocks", {2'h0, grp2, bpd, b0, b1, b2, b3}, 8'h00);
      rd(`BISW_OFF_STATUS, 8'h00);
      $display("test blocking done");
      wr(`BISW_OFF_ACTION_SEL, 8'h00);
      gsel <= 1'b1;
      cmd <= 1'b1;
      hold(6);
      chk("group other", {2'h0, grp2, bpd, b0, b1, b2, b3}, 8'h30);
      gsel <= 1'b0;
      hold(3);
      chk("group other", {7'h00, grp2}, 8'h00);
      cmd <= 1'b0;
      hold(6);
      $display("test group done");
      report_and_stop();
   end
endmodule : tb_bisw_top
